// ===== hdl/ddrap_pkg.sv
// constants, field layouts and encodings for the shared-address dram port block
// assumes a 32-bit apb register bus and two axi-style shared address ports
package ddrap_pkg;

   localparam int unsigned DDRAP_PORTS      = 2;
   localparam int unsigned DDRAP_ADDR_W     = 32;
   localparam int unsigned DDRAP_TAG_W      = 8;
   localparam int unsigned DDRAP_LEN_W      = 8;
   localparam int unsigned DDRAP_PADDR_W    = 12;
   localparam int unsigned DDRAP_P0_DATA_W  = 256;
   localparam int unsigned DDRAP_P1_DATA_W  = 128;

   // register byte offsets
   localparam logic [11:0] DDRAP_OFF_CTRL   = 12'h000;
   localparam logic [11:0] DDRAP_OFF_RATE   = 12'h004;
   localparam logic [11:0] DDRAP_OFF_CAL    = 12'h008;
   localparam logic [11:0] DDRAP_OFF_STAT   = 12'h00C;
   localparam logic [11:0] DDRAP_OFF_CNT0   = 12'h010;
   localparam logic [11:0] DDRAP_OFF_CNT1   = 12'h014;

   // field positions
   localparam int unsigned DDRAP_CTRL_EN    = 0;
   localparam int unsigned DDRAP_CTRL_STD   = 1;
   localparam int unsigned DDRAP_CTRL_X32   = 3;
   localparam int unsigned DDRAP_STAT_BUSY  = 0;
   localparam int unsigned DDRAP_STAT_RERR  = 2;

   // values after reset and limits
   localparam logic [10:0] DDRAP_RATE_MAX   = 11'h42A;
   localparam logic [10:0] DDRAP_RATE_RST   = 11'h42A;
   localparam logic [7:0]  DDRAP_TRIM_RST   = 8'h00;

   localparam logic        DDRAP_RW_READ    = 1'h0;
   localparam logic        DDRAP_RW_WRITE   = 1'h1;

   typedef enum logic [1:0] {
      DDRAP_BURST_FIXED = 2'h0,
      DDRAP_BURST_INCR  = 2'h1,
      DDRAP_BURST_WRAP  = 2'h2,
      DDRAP_BURST_RSVD  = 2'h3
   } ddrap_burst_t;

   typedef enum logic [1:0] {
      DDRAP_STD_DDR3   = 2'h0,
      DDRAP_STD_DDR3L  = 2'h1,
      DDRAP_STD_LPDDR3 = 2'h2,
      DDRAP_STD_LPDDR2 = 2'h3
   } ddrap_std_t;

   typedef enum logic [1:0] {
      DDRAP_ST_IDLE = 2'h0,
      DDRAP_ST_WALK = 2'h1
   } ddrap_state_t;

endpackage : ddrap_pkg

// ===== hdl/ddrap_top.sv
// shared read/write address ports of the dram controller with apb configuration
// assumes each port's fabric master runs on that port's own clock; apb on pclk
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module ddrap_port
   import ddrap_pkg::*;
#(
   parameter int unsigned DATA_W = DDRAP_P1_DATA_W
) (
   input  wire logic                    aclk,
   input  wire logic                    presetn,
   input  wire logic                    cfg_enable,
   input  wire logic                    address_valid,
   input  wire logic                    read_write_select,
   input  wire logic [DDRAP_ADDR_W-1:0] request_address,
   input  wire logic [DDRAP_TAG_W-1:0]  transaction_tag,
   input  wire logic [DDRAP_LEN_W-1:0]  burst_beat_count,
   input  wire logic [1:0]              burst_kind,
   input  wire logic [2:0]              beat_size,
   input  wire logic [1:0]              lock_kind,
   output logic                         address_ready,
   output logic                         beat_valid,
   output logic                         beat_write,
   output logic [DDRAP_ADDR_W-1:0]      beat_address,
   output logic [DDRAP_TAG_W-1:0]       beat_tag,
   output logic [1:0]                   beat_lock,
   output logic                         beat_last,
   output logic                         busy,
   output logic                         accept_toggle
);

   generate
      if (DATA_W != 128 && DATA_W != 256) begin : g_bad_width
         $error("ddrap_port: data width must be 128 or 256");
      end
   endgenerate

   typedef struct packed {
      ddrap_state_t            st;
      logic                    en_meta;
      logic                    en_sync;
      logic                    ready;
      logic [DDRAP_ADDR_W-1:0] addr;
      logic [DDRAP_LEN_W-1:0]  left;
      logic [1:0]              kind;
      logic [2:0]              size;
      logic [DDRAP_LEN_W-1:0]  len;
      logic [DDRAP_TAG_W-1:0]  tag;
      logic                    rw;
      logic [1:0]              lock;
      logic                    bvalid;
      logic                    last;
      logic                    tog;
   } ddrap_pst_t;

   ddrap_pst_t q;
   ddrap_pst_t d;

   // wrap length is a power of two in beats, so the mask is contiguous
   function automatic logic [DDRAP_ADDR_W-1:0] ddrap_next(
      input logic [DDRAP_ADDR_W-1:0] a,
      input logic [1:0]              k,
      input logic [2:0]              sz,
      input logic [DDRAP_LEN_W-1:0]  ln
   );
      logic [DDRAP_ADDR_W-1:0] bytes;
      logic [DDRAP_ADDR_W-1:0] mask;
      bytes = 32'h1 << sz;
      mask  = (bytes * ({24'h0, ln} + 32'h1)) - 32'h1;
      unique case (k)
         DDRAP_BURST_FIXED: ddrap_next = a;
         DDRAP_BURST_WRAP:  ddrap_next = (a & ~mask) | ((a + bytes) & mask);
         default:           ddrap_next = (a & ~(bytes - 32'h1)) + bytes;
      endcase
   endfunction : ddrap_next

   always_comb begin
      d         = q;
      d.en_meta = cfg_enable;
      d.en_sync = q.en_meta;
      d.bvalid  = 1'b0;
      unique case (q.st)
         DDRAP_ST_IDLE: begin
            if (address_valid && q.ready) begin
               d.st     = DDRAP_ST_WALK;
               d.ready  = 1'b0;
               d.addr   = request_address;
               d.left   = burst_beat_count;
               d.len    = burst_beat_count;
               d.kind   = burst_kind;
               d.size   = beat_size;
               d.tag    = transaction_tag;
               d.rw     = read_write_select;
               d.lock   = lock_kind;
               d.bvalid = 1'b1;
               d.last   = (burst_beat_count == 8'h00);
               d.tog    = ~q.tog;
            end else begin
               // not configured means no acceptance at all
               d.ready = q.en_sync;
            end
         end
         DDRAP_ST_WALK: begin
            if (q.left != 8'h00) begin
               d.addr   = ddrap_next(q.addr, q.kind, q.size, q.len);
               d.left   = q.left - 8'h01;
               d.bvalid = 1'b1;
               d.last   = (q.left == 8'h01);
            end else begin
               d.st = DDRAP_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge aclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign address_ready = q.ready;
   assign beat_valid    = q.bvalid;
   assign beat_write    = q.rw;
   assign beat_address  = q.addr;
   assign beat_tag      = q.tag;
   assign beat_lock     = q.lock;
   assign beat_last     = q.last;
   assign busy          = (q.st == DDRAP_ST_WALK);
   assign accept_toggle = q.tog;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!presetn);

   a_ready_not_walking: assert property (q.st == DDRAP_ST_WALK |-> !address_ready)
      else $error("address ready while walking a burst");
   a_take_first_beat: assert property (address_valid && address_ready |=>
      busy && beat_valid && beat_address == $past(request_address))
      else $error("taken request did not give its first beat");
   a_rw_carried: assert property (address_valid && address_ready |=>
      beat_write == $past(read_write_select))
      else $error("read/write select not carried");
   a_incr_step: assert property (beat_valid && !beat_last && q.kind == DDRAP_BURST_INCR |=>
      beat_valid && beat_address == (($past(beat_address) & ~((32'h1 << q.size) - 32'h1))
      + (32'h1 << q.size)))
      else $error("incrementing burst stepped wrongly");
   a_fixed_hold: assert property (beat_valid && !beat_last && q.kind == DDRAP_BURST_FIXED |=>
      beat_valid && $stable(beat_address))
      else $error("fixed burst address moved");
   a_single_beat: assert property (address_valid && address_ready && burst_beat_count == 8'h00 |=>
      beat_last ##1 !beat_valid ##1 !busy)
      else $error("single beat burst did not end");
   a_unconfigured_idle: assert property (!q.en_sync |=> !address_ready)
      else $error("ready without configuration");

endmodule : ddrap_port

module ddrap_top
   import ddrap_pkg::*;
(
   input  wire logic                                     pclk,
   input  wire logic                                     presetn,
   input  wire logic [DDRAP_PADDR_W-1:0]                 paddr,
   input  wire logic                                     psel,
   input  wire logic                                     penable,
   input  wire logic                                     pwrite,
   input  wire logic [31:0]                              pwdata,
   output logic [31:0]                                   prdata,
   output logic                                          pready,
   output logic                                          pslverr,
   input  wire logic [DDRAP_PORTS-1:0]                   aclk,
   input  wire logic [DDRAP_PORTS-1:0]                   address_valid,
   input  wire logic [DDRAP_PORTS-1:0]                   read_write_select,
   input  wire logic [DDRAP_PORTS-1:0][DDRAP_ADDR_W-1:0] request_address,
   input  wire logic [DDRAP_PORTS-1:0][DDRAP_TAG_W-1:0]  transaction_tag,
   input  wire logic [DDRAP_PORTS-1:0][DDRAP_LEN_W-1:0]  burst_beat_count,
   input  wire logic [DDRAP_PORTS-1:0][1:0]              burst_kind,
   input  wire logic [DDRAP_PORTS-1:0][2:0]              beat_size,
   input  wire logic [DDRAP_PORTS-1:0][1:0]              lock_kind,
   output logic [DDRAP_PORTS-1:0]                        address_ready,
   output logic [DDRAP_PORTS-1:0]                        beat_valid,
   output logic [DDRAP_PORTS-1:0]                        beat_write,
   output logic [DDRAP_PORTS-1:0][DDRAP_ADDR_W-1:0]      beat_address,
   output logic [DDRAP_PORTS-1:0][DDRAP_TAG_W-1:0]       beat_tag,
   output logic [DDRAP_PORTS-1:0][1:0]                   beat_lock,
   output logic [DDRAP_PORTS-1:0]                        beat_last,
   output logic [1:0]                                    phy_mem_std,
   output logic                                          phy_dq_x32,
   output logic [10:0]                                   phy_rate_mbps,
   output logic [7:0]                                    phy_trim
);

   typedef struct packed {
      logic                               en;
      logic [1:0]                         std;
      logic                               x32;
      logic [10:0]                        rate;
      logic                               rate_err;
      logic [7:0]                         trim;
      logic [DDRAP_PORTS-1:0]             busy_meta;
      logic [DDRAP_PORTS-1:0]             busy_sync;
      logic [DDRAP_PORTS-1:0]             tog_meta;
      logic [DDRAP_PORTS-1:0]             tog_sync;
      logic [DDRAP_PORTS-1:0]             tog_seen;
      logic [DDRAP_PORTS-1:0][31:0]       cnt;
      logic [31:0]                        rdata;
      logic                               ready;
      logic                               err;
   } ddrap_tst_t;

   ddrap_tst_t q;
   ddrap_tst_t d;

   logic [DDRAP_PORTS-1:0] port_busy;
   logic [DDRAP_PORTS-1:0] port_tog;
   logic                   setup;
   logic                   access;
   logic                   mapped;

   // port 0 carries the wide data path, port 1 the narrow one
   generate
      for (genvar i = 0; i < DDRAP_PORTS; i++) begin : g_port
         ddrap_port #(
            .DATA_W (i == 0 ? DDRAP_P0_DATA_W : DDRAP_P1_DATA_W)
         ) u_port (
            .aclk              (aclk[i]),
            .presetn           (presetn),
            .cfg_enable        (q.en),
            .address_valid     (address_valid[i]),
            .read_write_select (read_write_select[i]),
            .request_address   (request_address[i]),
            .transaction_tag   (transaction_tag[i]),
            .burst_beat_count  (burst_beat_count[i]),
            .burst_kind        (burst_kind[i]),
            .beat_size         (beat_size[i]),
            .lock_kind         (lock_kind[i]),
            .address_ready     (address_ready[i]),
            .beat_valid        (beat_valid[i]),
            .beat_write        (beat_write[i]),
            .beat_address      (beat_address[i]),
            .beat_tag          (beat_tag[i]),
            .beat_lock         (beat_lock[i]),
            .beat_last         (beat_last[i]),
            .busy              (port_busy[i]),
            .accept_toggle     (port_tog[i])
         );
      end
   endgenerate

   assign setup  = psel && !penable;
   assign access = psel && penable && q.ready;
   assign mapped = (paddr == DDRAP_OFF_CTRL) || (paddr == DDRAP_OFF_RATE) || (paddr == DDRAP_OFF_CAL)
                || (paddr == DDRAP_OFF_STAT) || (paddr == DDRAP_OFF_CNT0) || (paddr == DDRAP_OFF_CNT1);

   always_comb begin
      d           = q;
      d.busy_meta = port_busy;
      d.busy_sync = q.busy_meta;
      d.tog_meta  = port_tog;
      d.tog_sync  = q.tog_meta;
      d.tog_seen  = q.tog_sync;
      for (int i = 0; i < DDRAP_PORTS; i++) begin
         if (q.tog_sync[i] != q.tog_seen[i]) begin
            d.cnt[i] = q.cnt[i] + 32'h1;
         end
      end
      // one wait state-free access: answer is prepared in the setup cycle
      d.ready = setup;
      d.err   = setup && !mapped;
      d.rdata = 32'h0;
      if (setup && !pwrite) begin
         unique case (paddr)
            DDRAP_OFF_CTRL: d.rdata = {28'h0, q.x32, q.std, q.en};
            DDRAP_OFF_RATE: d.rdata = {21'h0, q.rate};
            DDRAP_OFF_CAL:  d.rdata = {24'h0, q.trim};
            DDRAP_OFF_STAT: d.rdata = {29'h0, q.rate_err, q.busy_sync};
            DDRAP_OFF_CNT0: d.rdata = q.cnt[0];
            DDRAP_OFF_CNT1: d.rdata = q.cnt[1];
            default:        d.rdata = 32'h0;
         endcase
      end
      if (access && pwrite && !q.err) begin
         unique case (paddr)
            DDRAP_OFF_CTRL: begin
               d.en  = pwdata[DDRAP_CTRL_EN];
               d.std = pwdata[DDRAP_CTRL_STD +: 2];
               d.x32 = pwdata[DDRAP_CTRL_X32];
            end
            DDRAP_OFF_RATE: begin
               // an out-of-range rate is refused and the old one kept
               if (pwdata[10:0] > DDRAP_RATE_MAX || pwdata[10:0] == 11'h000 || pwdata[31:11] != 21'h0) begin
                  d.rate_err = 1'b1;
               end else begin
                  d.rate     = pwdata[10:0];
                  d.rate_err = 1'b0;
               end
            end
            DDRAP_OFF_CAL: d.trim = pwdata[7:0];
            default: begin
               d.en = q.en;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q      <= '0;
         q.rate <= DDRAP_RATE_RST;
         q.trim <= DDRAP_TRIM_RST;
      end else begin
         q <= d;
      end
   end

   assign prdata  = q.rdata;
   assign pready  = q.ready;
   assign pslverr = q.err;
   // phy settings leave only from controller registers, no fabric bypass
   assign phy_mem_std   = q.std;
   assign phy_dq_x32    = q.x32;
   assign phy_rate_mbps = q.rate;
   assign phy_trim      = q.trim;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_rate_capped: assert property (phy_rate_mbps <= DDRAP_RATE_MAX && phy_rate_mbps != 11'h000)
      else $error("phy rate above its limit");
   a_rate_refused: assert property (access && pwrite && paddr == DDRAP_OFF_RATE && pwdata[10:0] > DDRAP_RATE_MAX
      |=> $stable(phy_rate_mbps) && q.rate_err)
      else $error("over-limit rate accepted");
   a_std_written: assert property (access && pwrite && paddr == DDRAP_OFF_CTRL |=>
      phy_mem_std == $past(pwdata[2:1]) && phy_dq_x32 == $past(pwdata[3]))
      else $error("standard or width not taken");
   a_apb_answer: assert property (setup |=> pready ##1 !pready)
      else $error("apb answer not one access cycle");
   a_unmapped_err: assert property (setup && !mapped |=> pslverr && pready)
      else $error("unmapped address not flagged");

endmodule : ddrap_top

`default_nettype wire

// ===== verification/ddrap_fabric_master.sv
// fabric master model for one shared address port of the dram controller
// assumes the bench calls issue() from its own thread and reads seen between bursts
`timescale 1ns/100ps
`default_nettype none

module ddrap_fabric_master
   import ddrap_pkg::*;
(
   input  wire logic                    aclk,
   input  wire logic                    address_ready,
   input  wire logic                    beat_valid,
   input  wire logic                    beat_last,
   input  wire logic [DDRAP_ADDR_W-1:0] beat_address,
   output logic                         address_valid,
   output logic                         read_write_select,
   output logic [DDRAP_ADDR_W-1:0]      request_address,
   output logic [DDRAP_TAG_W-1:0]       transaction_tag,
   output logic [DDRAP_LEN_W-1:0]       burst_beat_count,
   output logic [1:0]                   burst_kind,
   output logic [2:0]                   beat_size,
   output logic [1:0]                   lock_kind
);
   logic [33:0] seen[$];

   initial begin
      {address_valid, read_write_select, request_address, transaction_tag, burst_beat_count, burst_kind,
       beat_size, lock_kind} = '0;
   end

   // one entry per beat: ready level, last flag, beat address
   always @(posedge aclk) begin
      if (beat_valid === 1'b1) begin
         seen.push_back({address_ready, beat_last, beat_address});
      end
   end

   task automatic issue(input logic rw, input logic [31:0] a, input logic [7:0] ln, input logic [1:0] k,
                        input logic [2:0] sz, input logic [7:0] tag, input logic [1:0] lk, output logic ok);
      int n;
      n = 0;
      @(posedge aclk);
      address_valid <= 1'b1;
      {read_write_select, request_address, transaction_tag, burst_beat_count, burst_kind, beat_size,
       lock_kind} <= {rw, a, tag, ln, k, sz, lk};
      do begin
         @(posedge aclk);
         n++;
      end while (address_ready !== 1'b1 && n < 40);
      ok = (address_ready === 1'b1);
      address_valid <= 1'b0;
      // released fields flip so a stale capture cannot pass
      {read_write_select, request_address, transaction_tag, burst_beat_count, burst_kind, beat_size,
       lock_kind} <= ~{rw, a, tag, ln, k, sz, lk};
   endtask : issue

endmodule : ddrap_fabric_master
`default_nettype wire

// ===== verification/ddrap_top_bench.sv
// self-checking bench for the shared address ports with apb configuration
// assumes two fabric master models, apb master tasks here, pclk 25 ns, aclk 64 ns
`timescale 1ns/100ps
`default_nettype none

module ddrap_top_bench
   import ddrap_pkg::*;
;
   logic                                pclk = 1'b0;
   logic                                presetn = 1'b0;
   logic [11:0]                         paddr = '0;
   logic                                psel = 1'b0;
   logic                                penable = 1'b0;
   logic                                pwrite = 1'b0;
   logic [31:0]                         pwdata = '0;
   logic [1:0]                          aclk = 2'h0;
   wire logic [31:0]                    prdata;
   wire logic                           pready;
   wire logic                           pslverr;
   wire logic [1:0]                     address_valid, read_write_select, address_ready, beat_valid;
   wire logic [1:0]                     beat_write, beat_last, phy_mem_std;
   wire logic [1:0][31:0]               request_address, beat_address;
   wire logic [1:0][7:0]                transaction_tag, burst_beat_count, beat_tag;
   wire logic [1:0][1:0]                burst_kind, lock_kind, beat_lock;
   wire logic [1:0][2:0]                beat_size;
   wire logic                           phy_dq_x32;
   wire logic [10:0]                    phy_rate_mbps;
   wire logic [7:0]                     phy_trim;
   int                                  error_cnt = 0;
   int                                  cmp_count = 0;
   int                                  cyc = 0;

   always #12.5 pclk = ~pclk;
   always #32 aclk[0] = ~aclk[0];
   initial begin
      #9;
      forever #32 aclk[1] = ~aclk[1];
   end

   ddrap_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .aclk(aclk),
      .address_valid(address_valid), .read_write_select(read_write_select), .request_address(request_address),
      .transaction_tag(transaction_tag), .burst_beat_count(burst_beat_count), .burst_kind(burst_kind),
      .beat_size(beat_size), .lock_kind(lock_kind), .address_ready(address_ready), .beat_valid(beat_valid),
      .beat_write(beat_write), .beat_address(beat_address), .beat_tag(beat_tag), .beat_lock(beat_lock),
      .beat_last(beat_last), .phy_mem_std(phy_mem_std), .phy_dq_x32(phy_dq_x32),
      .phy_rate_mbps(phy_rate_mbps), .phy_trim(phy_trim));

   ddrap_fabric_master u_m0 (.aclk(aclk[0]), .address_ready(address_ready[0]), .beat_valid(beat_valid[0]),
      .beat_last(beat_last[0]), .beat_address(beat_address[0]), .address_valid(address_valid[0]),
      .read_write_select(read_write_select[0]), .request_address(request_address[0]),
      .transaction_tag(transaction_tag[0]), .burst_beat_count(burst_beat_count[0]),
      .burst_kind(burst_kind[0]), .beat_size(beat_size[0]), .lock_kind(lock_kind[0]));
   ddrap_fabric_master u_m1 (.aclk(aclk[1]), .address_ready(address_ready[1]), .beat_valid(beat_valid[1]),
      .beat_last(beat_last[1]), .beat_address(beat_address[1]), .address_valid(address_valid[1]),
      .read_write_select(read_write_select[1]), .request_address(request_address[1]),
      .transaction_tag(transaction_tag[1]), .burst_beat_count(burst_beat_count[1]),
      .burst_kind(burst_kind[1]), .beat_size(beat_size[1]), .lock_kind(lock_kind[1]));

   task automatic close_out();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // waits on pready as long as it takes; the global cycle ceiling catches a dead slave
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic experr);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      chk("write pslverr", {31'h0, experr}, {31'h0, e});
      repeat (2) @(posedge pclk);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk("prdata", exp, r);
      chk("read pslverr", {31'h0, experr}, {31'h0, e});
   endtask : rd

   function automatic logic [31:0] nxt(input logic [31:0] c, input logic [1:0] k, input logic [2:0] sz,
                                       input logic [7:0] ln);
      logic [31:0] b;
      logic [31:0] w;
      b = 32'h1 << sz;
      w = b * ({24'h0, ln} + 32'h1);
      if (k == 2'h0) return c;
      if (k == 2'h2) return (c & ~(w - 32'h1)) | ((c + b) & (w - 32'h1));
      return (c & ~(b - 32'h1)) + b;
   endfunction : nxt

   task automatic t_reset();
      chk("phy_rate_mbps", 32'h42A, {21'h0, phy_rate_mbps});
      chk("phy_trim", 32'h0, {24'h0, phy_trim});
      rd(DDRAP_OFF_CTRL, 32'h0, 1'b0);
      rd(DDRAP_OFF_RATE, 32'h42A, 1'b0);
      rd(DDRAP_OFF_STAT, 32'h0, 1'b0);
      repeat (40) @(posedge pclk);
      chk("address_ready before enable", 32'h0, {30'h0, address_ready});
   endtask : t_reset

   task automatic t_config();
      for (int s = 0; s < 4; s++) begin
         wr(DDRAP_OFF_CTRL, {28'h0, s[0], s[1:0], 1'b0}, 1'b0);
         chk("phy_mem_std", s, {30'h0, phy_mem_std});
         chk("phy_dq_x32", {31'h0, s[0]}, {31'h0, phy_dq_x32});
      end
      wr(DDRAP_OFF_CAL, 32'hA5, 1'b0);
      chk("phy_trim", 32'hA5, {24'h0, phy_trim});
      rd(DDRAP_OFF_CAL, 32'hA5, 1'b0);
      wr(12'h018, 32'h5A, 1'b1);
      rd(12'h018, 32'h0, 1'b1);
      rd(DDRAP_OFF_CAL, 32'hA5, 1'b0);
   endtask : t_config

   // pll, its pad reference and the fast clock sit outside; only the rate is kept here
   task automatic t_rate();
      wr(DDRAP_OFF_RATE, 32'h42B, 1'b0);
      chk("phy_rate_mbps", 32'h42A, {21'h0, phy_rate_mbps});
      rd(DDRAP_OFF_STAT, 32'h4, 1'b0);
      wr(DDRAP_OFF_RATE, 32'h0, 1'b0);
      rd(DDRAP_OFF_RATE, 32'h42A, 1'b0);
      wr(DDRAP_OFF_RATE, 32'h320, 1'b0);
      chk("phy_rate_mbps", 32'h320, {21'h0, phy_rate_mbps});
      rd(DDRAP_OFF_STAT, 32'h0, 1'b0);
   endtask : t_rate

   task automatic burst(input int p, input logic rw, input logic [31:0] a, input logic [7:0] ln,
                        input logic [1:0] k, input logic [2:0] sz);
      logic [33:0] q[$];
      logic [31:0] x;
      logic        ok;
      int          n;
      x = a;
      n = 0;
      if (p == 0) u_m0.issue(rw, a, ln, k, sz, a[7:0] ^ 8'h5A, k, ok);
      else u_m1.issue(rw, a, ln, k, sz, a[7:0] ^ 8'h5A, k, ok);
      chk("request taken", 32'h1, {31'h0, ok});
      do begin
         @(posedge pclk);
         n++;
         if (p == 0) q = u_m0.seen;
         else q = u_m1.seen;
      end while (q.size() < ln + 1 && n < 400);
      repeat (12) @(posedge pclk);
      if (p == 0) q = u_m0.seen;
      else q = u_m1.seen;
      chk("beat count", {24'h0, ln} + 32'h1, q.size());
      foreach (q[i]) begin
         chk("beat_address", x, q[i][31:0]);
         chk("beat_last", (i == ln), {31'h0, q[i][32]});
         chk("address_ready in burst", 32'h0, {31'h0, q[i][33]});
         x = nxt(x, k, sz, ln);
      end
      chk("beat_write", {31'h0, rw}, {31'h0, beat_write[p]});
      chk("beat_tag", {24'h0, a[7:0] ^ 8'h5A}, {24'h0, beat_tag[p]});
      chk("beat_lock", {30'h0, k}, {30'h0, beat_lock[p]});
      if (p == 0) u_m0.seen.delete();
      else u_m1.seen.delete();
   endtask : burst

   task automatic t_bursts();
      wr(DDRAP_OFF_CTRL, 32'h1, 1'b0);
      burst(0, DDRAP_RW_WRITE, 32'h10, 8'h1, DDRAP_BURST_INCR, 3'h2);
      burst(0, DDRAP_RW_WRITE, 32'h18, 8'h3, DDRAP_BURST_WRAP, 3'h2);
      burst(0, DDRAP_RW_READ, 32'h40, 8'h2, DDRAP_BURST_FIXED, 3'h3);
      burst(1, DDRAP_RW_READ, 32'h100, 8'h1, DDRAP_BURST_RSVD, 3'h4);
   endtask : t_bursts

   task automatic t_counts();
      repeat (10) @(posedge pclk);
      rd(DDRAP_OFF_CNT0, 32'h3, 1'b0);
      rd(DDRAP_OFF_CNT1, 32'h1, 1'b0);
      rd(DDRAP_OFF_STAT, 32'h0, 1'b0);
   endtask : t_counts

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_config();
      t_rate();
      t_bursts();
      t_counts();
      close_out();
   end

endmodule : ddrap_top_bench
`default_nettype wire
